// ===== verilog/scri_system_ctrl.sv
// System clock, reset sequencing and status registers on an AHB-Lite slave
// How it works
// - Bus clock is the clock generator output divided by two.
// - Bus rate is oscillator/4 or PLL/4 according to the source select.
// - After power-on or low voltage, CPU/peripheral clocks off for 4096 cycles.
// - Reset pin driven low for the whole stabilisation timeout.
// - Bus clocks start only once the stabilisation timeout ends.
// - Wait mode stops the CPU clock.
// - Wait mode keeps two separate module clock sets running.
// - Read-only reset cause register reports last reset sources, resets 0x80.
// - Break flag control holds clear-enable at bit 7, reset 0, rest reserved.
// - Vector logic is structured to scale up to 128 interrupt sources.
// - Every reset source sets its own cause flag.
// - Power-on sets its flag and clears all other cause bits.
// - After the timeout, 64 more cycles pass before the CPU leaves reset.
// - Internal reset: pin low 32 cycles, internal reset 32 cycles more.
module scri_system_ctrl #(
	parameter int STAB_CYCLES = scri_pkg::STAB_CYCLES,
	parameter int NUM_IRQ     = 128
) (
	input  wire logic                      hclk,
	input  wire logic                      hresetn,
	input  wire logic                      hsel,
	input  wire logic [scri_pkg::ADDR_W-1:0] haddr,
	input  wire logic [1:0]                htrans,
	input  wire logic                      hwrite,
	input  wire logic [2:0]                hsize,
	input  wire logic [31:0]               hwdata,
	input  wire logic                      hready,
	output logic                           hreadyout,
	output logic [31:0]                    hrdata,
	output logic                           hresp,
	input  wire logic                      osc_buffered_clock,
	input  wire logic                      pll_vco_clock,
	input  wire logic                      power_on_pulse,
	input  wire logic                      low_voltage_in,
	input  wire logic                      watchdog_in,
	input  wire logic                      bad_opcode_in,
	input  wire logic                      bad_fetch_in,
	input  wire logic                      wait_enter,
	input  wire logic                      wake_event,
	input  wire logic                      break_in_wait,
	input  wire logic [NUM_IRQ-1:0]        irq_req,
	input  wire logic                      rst_pin_in,
	output logic                           rst_pin_out,
	output logic                           rst_pin_oe,
	output logic                           internal_reset,
	output logic                           clock_gen_output,
	output logic                           bus_clk,
	output logic                           cpu_clk_en,
	output logic                           periph_clk_en,
	output logic                           periph_wait_clk_en,
	output logic                           irq_pending,
	output logic [6:0]                     irq_vector,
	output logic                           irq
);

	localparam int CW = scri_pkg::CNT_W;

	if (STAB_CYCLES < 64 || STAB_CYCLES > 8192) begin : g_chk_stab
		$error("STAB_CYCLES out of range");
	end
	if (NUM_IRQ < 1 || NUM_IRQ > 128) begin : g_chk_irq
		$error("NUM_IRQ out of range");
	end

	// Lowest numbered request wins; index widened so 128 sources fit
	function automatic logic [6:0] first_set(input logic [NUM_IRQ-1:0] v);
		logic [6:0] r;
		r = 7'h00;
		for (int i = NUM_IRQ - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = 7'(i);
			end
		end
		return r;
	endfunction : first_set

	// Three-stage pin synchroniser with agreement filter
	logic [scri_pkg::NSYNC-1:0] pin_raw;
	logic [scri_pkg::NSYNC-1:0] s1_r, s2_r, s3_r, lvl_r, lvl_d_r;
	assign pin_raw = {watchdog_in, low_voltage_in, power_on_pulse,
	                  rst_pin_in, pll_vco_clock, osc_buffered_clock};

	for (genvar g = 0; g < scri_pkg::NSYNC; g++) begin : g_sync
		localparam logic RV = scri_pkg::SYNC_RST[g];
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				s1_r[g]    <= RV;
				s2_r[g]    <= RV;
				s3_r[g]    <= RV;
				lvl_r[g]   <= RV;
				lvl_d_r[g] <= RV;
			end else begin
				s1_r[g]    <= pin_raw[g];
				s2_r[g]    <= s1_r[g];
				s3_r[g]    <= s2_r[g];
				lvl_d_r[g] <= lvl_r[g];
				if (s2_r[g] == s3_r[g]) begin
					lvl_r[g] <= s3_r[g];
				end
			end
		end
	end

	wire [scri_pkg::NSYNC-1:0] rise = lvl_r & ~lvl_d_r;
	wire osc_tick  = rise[scri_pkg::SYN_OSC];
	wire pin_low   = ~lvl_r[scri_pkg::SYN_RPIN];

	// Register state
	logic                    clk_sel_r, brk_wait_r, break_clear_enable_r, wait_r;
	logic [7:0]              rst_cause_r;
	logic [scri_pkg::EVT_W-1:0] evt_stat_r, evt_en_r;
	logic                    cgm_r, bus_r;
	logic [CW-1:0]           cnt_r;
	scri_pkg::scri_state_t   st_r, st_nxt;
	scri_pkg::scri_wreq_t    wreq_r;

	// Clock generator output and bus clock dividers
	wire src_tick = clk_sel_r ? rise[scri_pkg::SYN_PLL] : osc_tick;
	wire cgm_tick = src_tick & ~cgm_r;
	wire bus_tick = cgm_tick & ~bus_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cgm_r <= 1'b0;
			bus_r <= 1'b0;
		end else begin
			if (src_tick) begin
				cgm_r <= ~cgm_r;
			end
			if (cgm_tick) begin
				bus_r <= ~bus_r;
			end
		end
	end

	// Reset sequencer
	wire por_evt  = rise[scri_pkg::SYN_POR];
	wire lvi_evt  = rise[scri_pkg::SYN_LVI];
	wire int_evt  = rise[scri_pkg::SYN_WDOG] | bad_opcode_in | bad_fetch_in;
	wire ext_evt  = pin_low & (st_r == scri_pkg::ST_RUN);
	wire stab_end = osc_tick && cnt_r == CW'(STAB_CYCLES - 1);
	wire low_end  = osc_tick && cnt_r == CW'(scri_pkg::PIN_LOW_CYCLES - 1);
	wire hold_end = osc_tick && !pin_low &&
	                cnt_r == CW'(scri_pkg::HOLD_CYCLES - 1);
	wire restart  = por_evt | lvi_evt | int_evt | ext_evt;
	wire phase_end;

	always_comb begin
		st_nxt = st_r;
		if (por_evt || lvi_evt) begin
			st_nxt = scri_pkg::ST_STAB;
		end else if (int_evt) begin
			st_nxt = scri_pkg::ST_PINLOW;
		end else if (ext_evt) begin
			st_nxt = scri_pkg::ST_HOLD;
		end else begin
			case (st_r)
				scri_pkg::ST_STAB: begin
					if (stab_end) st_nxt = scri_pkg::ST_PINLOW;
				end
				scri_pkg::ST_PINLOW: begin
					if (low_end) st_nxt = scri_pkg::ST_HOLD;
				end
				scri_pkg::ST_HOLD: begin
					if (hold_end) st_nxt = scri_pkg::ST_RUN;
				end
				scri_pkg::ST_RUN: st_nxt = scri_pkg::ST_RUN;
				default: st_nxt = scri_pkg::ST_STAB;
			endcase
		end
	end
	assign phase_end = st_nxt != st_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r  <= scri_pkg::ST_STAB;
			cnt_r <= '0;
		end else begin
			st_r <= st_nxt;
			// External pin held low keeps the hold phase at its start
			if (restart || phase_end || (st_r == scri_pkg::ST_HOLD && pin_low)) begin
				cnt_r <= '0;
			end else if (osc_tick && st_r != scri_pkg::ST_RUN) begin
				cnt_r <= cnt_r + CW'(1);
			end
		end
	end

	wire stab   = st_r == scri_pkg::ST_STAB;
	wire in_run = st_r == scri_pkg::ST_RUN;

	// AHB-Lite slave: zero wait states, always OKAY
	wire        acc   = hsel & htrans[1] & hready;
	wire [15:0] a_idx = haddr[scri_pkg::ADDR_W-1:2];
	wire        w_dat = wreq_r.valid;
	wire        wr_brk   = w_dat && wreq_r.idx == scri_pkg::IDX_BRK_STAT;
	wire        wr_bctl  = w_dat && wreq_r.idx == scri_pkg::IDX_BRK_CTRL;
	wire        wr_cctl  = w_dat && wreq_r.idx == scri_pkg::IDX_CLK_CTRL;
	wire        wr_eclr  = w_dat && wreq_r.idx == scri_pkg::IDX_EVT_CLR;
	wire        wr_een   = w_dat && wreq_r.idx == scri_pkg::IDX_EVT_EN;
	logic [31:0] rd_mux;

	always_comb begin
		case (a_idx)
			scri_pkg::IDX_BRK_STAT:  rd_mux = {30'h0, brk_wait_r, 1'b0};
			scri_pkg::IDX_RST_CAUSE: rd_mux = {24'h0, rst_cause_r};
			scri_pkg::IDX_BRK_CTRL:  rd_mux = {24'h0, break_clear_enable_r, 7'h00};
			scri_pkg::IDX_CLK_CTRL:  rd_mux = {31'h0, clk_sel_r};
			scri_pkg::IDX_EVT_STAT:  rd_mux = {28'h0, evt_stat_r};
			scri_pkg::IDX_EVT_EN:    rd_mux = {28'h0, evt_en_r};
			scri_pkg::IDX_VECTOR:    rd_mux = {20'h0, st_r, irq_pending,
			                                   irq_vector};
			default:                 rd_mux = 32'h0;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wreq_r    <= '0;
			hrdata    <= 32'h0;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			wreq_r.valid <= acc & hwrite & (haddr[1:0] == 2'h0);
			wreq_r.idx   <= a_idx;
			hreadyout    <= 1'b1;
			hresp        <= 1'b0;
			if (acc && !hwrite) begin
				hrdata <= (haddr[1:0] == 2'h0) ? rd_mux : 32'h0;
			end
		end
	end

	// Software registers and status flags
	logic [7:0] cause_nxt;
	logic [scri_pkg::EVT_W-1:0] evt_set;
	always_comb begin
		cause_nxt = rst_cause_r;
		cause_nxt[scri_pkg::CAUSE_PIN]  |= ext_evt;
		cause_nxt[scri_pkg::CAUSE_WDOG] |= rise[scri_pkg::SYN_WDOG];
		cause_nxt[scri_pkg::CAUSE_OPC]  |= bad_opcode_in;
		cause_nxt[scri_pkg::CAUSE_ADR]  |= bad_fetch_in;
		cause_nxt[scri_pkg::CAUSE_LVI]  |= lvi_evt;
		if (por_evt) begin
			cause_nxt = scri_pkg::RST_CAUSE_RST;
		end
		evt_set = '0;
		evt_set[scri_pkg::EVT_SEQ_DONE] = hold_end && st_r == scri_pkg::ST_HOLD;
		evt_set[scri_pkg::EVT_WAIT_IN]  = wait_enter & in_run;
		evt_set[scri_pkg::EVT_WAKE]     = wake_event & wait_r;
		evt_set[scri_pkg::EVT_EXT_RST]  = ext_evt;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rst_cause_r <= scri_pkg::RST_CAUSE_RST;
			brk_wait_r  <= scri_pkg::BRK_STAT_RST[scri_pkg::BRK_WAIT_BIT];
			break_clear_enable_r      <= scri_pkg::BRK_CTRL_RST[scri_pkg::BREAK_CLEAR_ENABLE_BIT];
			clk_sel_r   <= scri_pkg::CLK_CTRL_RST[scri_pkg::CLK_SEL_BIT];
			evt_stat_r  <= '0;
			evt_en_r    <= scri_pkg::EVT_EN_RST;
			wait_r      <= 1'b0;
		end else begin
			rst_cause_r <= cause_nxt;
			// Hardware set beats a clearing write in the same cycle
			if (break_in_wait) begin
				brk_wait_r <= 1'b1;
			end else if (wr_brk && !hwdata[scri_pkg::BRK_WAIT_BIT]) begin
				brk_wait_r <= 1'b0;
			end
			// Any reset source returns the control bit to its reset value
			if (restart) begin
				break_clear_enable_r <= scri_pkg::BRK_CTRL_RST[scri_pkg::BREAK_CLEAR_ENABLE_BIT];
			end else if (wr_bctl) begin
				break_clear_enable_r <= hwdata[scri_pkg::BREAK_CLEAR_ENABLE_BIT];
			end
			if (wr_cctl) clk_sel_r <= hwdata[scri_pkg::CLK_SEL_BIT];
			if (wr_een) evt_en_r <= hwdata[scri_pkg::EVT_W-1:0];
			evt_stat_r <= (evt_stat_r &
			               ~(wr_eclr ? hwdata[scri_pkg::EVT_W-1:0] : '0)) |
			              evt_set;
			if (!in_run || wake_event) begin
				wait_r <= 1'b0;
			end else if (wait_enter) begin
				wait_r <= 1'b1;
			end
		end
	end

	// Registered clock enables, reset pin and interrupt outputs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rst_pin_out        <= 1'b0;
			rst_pin_oe         <= 1'b1;
			internal_reset     <= 1'b1;
			clock_gen_output   <= 1'b0;
			bus_clk            <= 1'b0;
			cpu_clk_en         <= 1'b0;
			periph_clk_en      <= 1'b0;
			periph_wait_clk_en <= 1'b0;
			irq_pending        <= 1'b0;
			irq_vector         <= 7'h00;
			irq                <= 1'b0;
		end else begin
			rst_pin_out        <= 1'b0;
			rst_pin_oe         <= stab | (st_r == scri_pkg::ST_PINLOW);
			internal_reset     <= !in_run;
			clock_gen_output   <= cgm_r;
			bus_clk            <= bus_r;
			cpu_clk_en         <= bus_tick & !stab & !wait_r;
			periph_clk_en      <= bus_tick & !stab;
			periph_wait_clk_en <= cgm_tick & !stab;
			irq_pending        <= |irq_req;
			irq_vector         <= first_set(irq_req);
			irq                <= |(evt_stat_r & evt_en_r);
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	AST_BUS_DIV: assert property ($changed(bus_r) |-> $rose(cgm_r))
		else $error("bus tick without clock generator tick");
	AST_SRC_SEL: assert property ($changed(cgm_r) |-> $past(src_tick))
		else $error("clock generator output moved off source edge");
	AST_STAB_OFF: assert property (stab |=> !periph_clk_en && !cpu_clk_en)
		else $error("clocks running during stabilisation");
	AST_PIN_DRIVE: assert property (stab |=> rst_pin_oe && !rst_pin_out)
		else $error("reset pin not driven during stabilisation");
	AST_CLK_START: assert property ((st_r == scri_pkg::ST_PINLOW && bus_tick) |=> periph_clk_en)
		else $error("bus clocks not started after timeout");
	AST_WAIT_CPU: assert property (wait_r |=> !cpu_clk_en)
		else $error("CPU clock running in wait");
	AST_WAIT_MOD: assert property ((wait_r && cgm_tick && in_run) |=> periph_wait_clk_en)
		else $error("module clock stopped in wait");
	AST_BRK_SET: assert property (break_in_wait |=> brk_wait_r)
		else $error("break-wait set lost");
	AST_POR_CAUSE: assert property (por_evt |=> rst_cause_r == 8'h80)
		else $error("power-on cause not exclusive");
	AST_INT_HOLD: assert property ($fell(rst_pin_oe) |-> internal_reset)
		else $error("internal reset released with pin");
	AST_CNT_LIM: assert property (st_r == scri_pkg::ST_PINLOW |-> cnt_r < 13'h0020)
		else $error("pin low phase overran");
	AST_VEC: assert property ((irq_req == '0) |=> !irq_pending)
		else $error("vector pending with no request");

	COV_POR_SEQ: cover property (stab ##1 st_r == scri_pkg::ST_PINLOW);
	COV_RUN: cover property (st_r == scri_pkg::ST_HOLD ##1 in_run);
	COV_WAIT: cover property (wait_r ##1 wake_event);
	COV_IRQ: cover property (irq);

endmodule : scri_system_ctrl

// ===== verilog/scri_pkg.sv
// Shared constants, types and register map of the system clock/reset unit
package scri_pkg;

	// Bus address width and register indices (byte address = 4 * index)
	localparam int          ADDR_W        = 18;
	localparam logic [15:0] IDX_BRK_STAT  = 16'hfe00;
	localparam logic [15:0] IDX_RST_CAUSE = 16'hfe01;
	localparam logic [15:0] IDX_BRK_CTRL  = 16'hfe03;
	localparam logic [15:0] IDX_CLK_CTRL  = 16'hfe04;
	localparam logic [15:0] IDX_EVT_STAT  = 16'hfe05;
	localparam logic [15:0] IDX_EVT_CLR   = 16'hfe06;
	localparam logic [15:0] IDX_EVT_EN    = 16'hfe07;
	localparam logic [15:0] IDX_VECTOR    = 16'hfe08;

	// Field positions
	localparam int BRK_WAIT_BIT = 1;
	localparam int BREAK_CLEAR_ENABLE_BIT     = 7;
	localparam int CLK_SEL_BIT  = 0;
	localparam int CAUSE_POR    = 7;
	localparam int CAUSE_PIN    = 6;
	localparam int CAUSE_WDOG   = 5;
	localparam int CAUSE_OPC    = 4;
	localparam int CAUSE_ADR    = 3;
	localparam int CAUSE_LVI    = 1;

	// Reset values
	localparam logic [7:0] BRK_STAT_RST  = 8'h00;
	localparam logic [7:0] RST_CAUSE_RST = 8'h80;
	localparam logic [7:0] BRK_CTRL_RST  = 8'h00;
	localparam logic [7:0] CLK_CTRL_RST  = 8'h00;

	// Sequence lengths in buffered oscillator cycles
	localparam int STAB_CYCLES    = 4096;
	localparam int PIN_LOW_CYCLES = 32;
	localparam int HOLD_CYCLES    = 32;
	localparam int CNT_W          = 13;

	// Event status bits
	localparam int         EVT_W        = 4;
	localparam int         EVT_SEQ_DONE = 0;
	localparam int         EVT_WAIT_IN  = 1;
	localparam int         EVT_WAKE     = 2;
	localparam int         EVT_EXT_RST  = 3;
	localparam logic [3:0] EVT_EN_RST   = 4'h0;

	// Pins passed through the three-stage synchroniser
	localparam int         NSYNC    = 6;
	localparam int         SYN_OSC  = 0;
	localparam int         SYN_PLL  = 1;
	localparam int         SYN_RPIN = 2;
	localparam int         SYN_POR  = 3;
	localparam int         SYN_LVI  = 4;
	localparam int         SYN_WDOG = 5;
	localparam logic [5:0] SYNC_RST = 6'h04;

	typedef enum logic [3:0] {
		ST_STAB   = 4'b0001,
		ST_PINLOW = 4'b0010,
		ST_HOLD   = 4'b0100,
		ST_RUN    = 4'b1000
	} scri_state_t;

	typedef struct packed {
		logic        valid;
		logic [15:0] idx;
	} scri_wreq_t;

endpackage : scri_pkg

// ===== verif/scri_far_side.sv
// Far-side model: oscillator, PLL clock and the pulled-up reset wire
module scri_far_side (
	input  wire logic rst_pin_out,
	input  wire logic rst_pin_oe,
	input  wire logic ext_low,
	output logic      osc_buffered_clock,
	output logic      pll_vco_clock,
	output logic      rst_pin_in
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		osc_buffered_clock = 1'b0;
		pll_vco_clock = 1'b0;
	end

	// Both clocks stay well below an eighth of the bus clock rate
	always #200 osc_buffered_clock = ~osc_buffered_clock;
	always #150 pll_vco_clock = ~pll_vco_clock;

	// Wire with pull-up: low when either party pulls it down
	assign rst_pin_in = ((rst_pin_oe && !rst_pin_out) || ext_low) ? 1'b0 : 1'b1;
endmodule : scri_far_side

// ===== verif/system_clock_reset_integration_test.sv
// Self-checking bench of the system clock and reset controller
module system_clock_reset_integration_test;
	timeunit 1ns;
	timeprecision 100ps;

	localparam logic [17:0] A_BRK = 18'h3f800;
	localparam logic [17:0] A_CAU = 18'h3f804;
	localparam logic [17:0] A_BCT = 18'h3f80c;
	localparam logic [17:0] A_CLK = 18'h3f810;
	localparam logic [17:0] A_EVS = 18'h3f814;
	localparam logic [17:0] A_EVC = 18'h3f818;
	localparam logic [17:0] A_EVE = 18'h3f81c;
	localparam logic [17:0] A_VEC = 18'h3f820;

	logic         hclk, hresetn, hsel, hwrite, hreadyout, ext_low, irq;
	logic         osc, pll, rst_in, rst_out, rst_oe, internal_reset;
	logic         cpu_clk_en, periph_clk_en, periph_wait_clk_en;
	logic         hresp, bus_clk, cgo, bp, gp;
	logic [17:0]  haddr;
	logic [1:0]   htrans;
	logic [2:0]   hsize;
	logic [31:0]  hwdata, hrdata, r;
	logic [7:0]   ev;
	logic [127:0] irq_req;
	int           n_mismatch, comparisons, c, p, w, bk, gk;

	scri_system_ctrl #(.STAB_CYCLES(64)) u_dut (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hrdata, .hresp,
		.osc_buffered_clock(osc), .pll_vco_clock(pll),
		.power_on_pulse(ev[7]), .low_voltage_in(ev[0]),
		.watchdog_in(ev[1]), .bad_opcode_in(ev[2]), .bad_fetch_in(ev[3]),
		.wait_enter(ev[4]), .wake_event(ev[5]), .break_in_wait(ev[6]),
		.irq_req, .rst_pin_in(rst_in), .rst_pin_out(rst_out),
		.rst_pin_oe(rst_oe), .internal_reset, .clock_gen_output(cgo),
		.bus_clk, .cpu_clk_en, .periph_clk_en, .periph_wait_clk_en,
		.irq_pending(), .irq_vector(), .irq
	);

	scri_far_side u_far (
		.rst_pin_out(rst_out), .rst_pin_oe(rst_oe), .ext_low,
		.osc_buffered_clock(osc), .pll_vco_clock(pll), .rst_pin_in(rst_in)
	);

	always #12.5 hclk = ~hclk;

	task chk(string nm, logic [31:0] e, logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task rng(string nm, int lo, int hi, int g);
		comparisons++;
		if (g < lo || g > hi) begin
			n_mismatch++;
			$display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, g);
		end
	endtask : rng

	// Single AHB-Lite transfer: address phase, then data phase
	task xfer(logic wr, logic [17:0] a, logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= wr;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		r = hrdata;
	endtask : xfer

	task rdchk(string nm, logic [17:0] a, logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(nm, e, r);
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask : rdchk

	task pulse(int b, int n);
		@(posedge hclk);
		ev[b] <= 1'b1;
		repeat (n) @(posedge hclk);
		ev[b] <= 1'b0;
	endtask : pulse

	// Counts oscillator edges while the pin is driven and until release
	task seq(int oe_exp, int ir_exp);
		int   oe_n, ir_n, k, bad;
		logic po;
		oe_n = 0;
		ir_n = 0;
		k = 0;
		bad = 0;
		// Same-clock sources reach the reset output a cycle after the pulse
		while (internal_reset !== 1'b1 && k < 16) begin
			@(posedge hclk);
			k++;
		end
		po = osc;
		while (internal_reset !== 1'b0 && k < 20000) begin
			@(posedge hclk);
			k++;
			if (osc && !po) begin
				oe_n += (rst_oe === 1'b1);
				ir_n++;
			end
			// Clocks stay off while the stabilisation count runs
			if (rst_oe === 1'b1 && oe_n < oe_exp - 34 &&
			    (cpu_clk_en !== 1'b0 || periph_clk_en !== 1'b0)) bad++;
			po = osc;
		end
		rng("pin driven cycles", oe_exp - 3, oe_exp + 3, oe_n);
		rng("internal reset cycles", ir_exp - 3, ir_exp + 3, ir_n);
		chk("clocks during stabilisation", 32'h0, bad);
	endtask : seq

	task cnt();
		c = 0;
		p = 0;
		w = 0;
		bk = 0;
		gk = 0;
		bp = bus_clk;
		gp = cgo;
		repeat (960) begin
			@(posedge hclk);
			c += (cpu_clk_en === 1'b1);
			p += (periph_clk_en === 1'b1);
			w += (periph_wait_clk_en === 1'b1);
			bk += (bus_clk === 1'b1 && bp === 1'b0);
			gk += (cgo === 1'b1 && gp === 1'b0);
			bp = bus_clk;
			gp = cgo;
		end
	endtask : cnt

	task t_regs();
		rdchk("cause reset", A_CAU, 32'h80);
		rdchk("break status reset", A_BRK, 32'h0);
		rdchk("break ctrl reset", A_BCT, 32'h0);
		xfer(1'b1, A_BCT, 32'hff);
		rdchk("break ctrl reserved", A_BCT, 32'h80);
		xfer(1'b1, A_CAU, 32'h0);
		rdchk("cause after write", A_CAU, 32'h80);
		pulse(6, 1);
		rdchk("break wait set", A_BRK, 32'h2);
		xfer(1'b1, A_BRK, 32'hff);
		rdchk("break wait write one", A_BRK, 32'h2);
		xfer(1'b1, A_BRK, 32'h0);
		rdchk("break wait cleared", A_BRK, 32'h0);
		rdchk("unmapped", 18'h3f808, 32'h0);
	endtask : t_regs

	task t_clocks();
		cnt();
		rng("bus rate osc", 14, 16, c);
		rng("clock gen rate osc", 29, 31, w);
		rng("bus clock osc", 14, 16, bk);
		rng("clock gen output osc", 29, 31, gk);
		xfer(1'b1, A_CLK, 32'h1);
		repeat (64) @(posedge hclk);
		cnt();
		rng("bus rate pll", 19, 21, c);
		rng("clock gen rate pll", 39, 41, w);
		rng("bus clock pll", 19, 21, bk);
		rng("clock gen output pll", 39, 41, gk);
		xfer(1'b1, A_CLK, 32'h0);
		repeat (64) @(posedge hclk);
	endtask : t_clocks

	task t_wait_irq();
		xfer(1'b1, A_EVC, 32'hf);
		xfer(1'b1, A_EVE, 32'h0);
		pulse(4, 1);
		cnt();
		chk("cpu clock in wait", 32'h0, c);
		rng("bus set in wait", 14, 16, p);
		rng("fast set in wait", 29, 31, w);
		rdchk("wait event", A_EVS, 32'h2);
		repeat (2) @(posedge hclk);
		chk("irq masked", 32'h0, irq);
		xfer(1'b1, A_EVE, 32'h2);
		repeat (2) @(posedge hclk);
		chk("irq raised", 32'h1, irq);
		pulse(5, 1);
		rdchk("wake event", A_EVS, 32'h6);
		xfer(1'b1, A_EVC, 32'h6);
		repeat (2) @(posedge hclk);
		chk("irq cleared", 32'h0, irq);
		// Top source and source 5 together: the lower index must win
		irq_req <= {1'b1, 127'h20};
		repeat (3) @(posedge hclk);
		xfer(1'b0, A_VEC, 32'h0);
		chk("vector", 32'h85, {24'h0, r[7:0]});
		irq_req <= 128'h0;
	endtask : t_wait_irq

	task t_sources();
		int bits[4];
		bits = '{1, 5, 4, 3};
		for (int i = 0; i < 4; i++) begin
			pulse(i, (i < 2) ? 8 : 1);
			seq((i == 0) ? 96 : 32, (i == 0) ? 128 : 64);
			xfer(1'b0, A_CAU, 32'h0);
			chk("cause source bit", 32'h1, {31'h0, r[bits[i]]});
		end
	endtask : t_sources

	task t_pin();
		@(posedge hclk);
		ext_low <= 1'b1;
		repeat (100) @(posedge hclk);
		ext_low <= 1'b0;
		repeat (1200) @(posedge hclk);
		chk("pin reset released", 32'h0, internal_reset);
		xfer(1'b0, A_CAU, 32'h0);
		chk("cause pin bit", 32'h1, {31'h0, r[6]});
		xfer(1'b0, A_EVS, 32'h0);
		chk("pin event bit", 32'h1, {31'h0, r[3]});
	endtask : t_pin

	task t_repor();
		xfer(1'b1, A_BCT, 32'h80);
		pulse(7, 8);
		seq(96, 128);
		rdchk("cause after power-on", A_CAU, 32'h80);
		rdchk("break ctrl after power-on", A_BCT, 32'h0);
	endtask : t_repor

	task conclude();
		$display("Comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : conclude

	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		{hsel, hwrite, ext_low} = 3'h0;
		haddr = 18'h0;
		htrans = 2'h0;
		hsize = 3'h2;
		hwdata = 32'h0;
		ev = 8'h0;
		irq_req = 128'h0;
		n_mismatch = 0;
		comparisons = 0;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		seq(96, 128);
		t_regs();
		t_clocks();
		t_wait_irq();
		t_sources();
		t_pin();
		t_repor();
		conclude();
	end

	initial begin
		repeat (60000) @(posedge hclk);
		n_mismatch++;
		$display("Watchdog expired before the tests ended");
		conclude();
	end
endmodule : system_clock_reset_integration_test
